// >>> design/ddr_dev.sv
// Device end: mode registers, preamble training and MPR read bursts
`include "ddr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ddr_dev (
  // System
  input wire logic clock,
  input wire logic rst,
  // Link
  ddr_link_if.dev link,
  // Status
  output logic mpr_on,
  output logic train_on,
  output logic strobe_ready,
  output logic rd_pre2,
  output logic wr_pre2,
  output logic cmd_err,
  output logic wpost_err,
  output logic [1:0] last_group
);
  ddr_pkg::ddr_dev_st_t st_reg, st_next;
  logic mpr_reg, mpr_next;
  logic [1:0] page_reg, page_next;
  logic train_reg, train_next;
  logic rpre2_reg, rpre2_next;
  logic wpre2_reg, wpre2_next;
  logic [7:0] mpr_data_reg [4];
  logic [1:0] sel_reg, sel_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [1:0] beat_reg, beat_next;
  logic [31:0] dq_reg, dq_next;
  logic dqoe_reg, dqoe_next;
  logic [1:0] st_t_reg, st_t_next;
  logic [1:0] st_c_reg, st_c_next;
  logic [1:0] soe_reg, soe_next;
  logic sready_reg, sready_next;
  logic cerr_reg, cerr_next;
  logic werr_reg, werr_next;
  logic [4:0] wc_reg, wc_next;
  logic [1:0] grp_reg, grp_next;
  logic [2:0] mr;
  logic [7:0] byte_sel;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // One beat: two UIs, MSB first, on all sixteen lines
  function automatic logic [31:0] beat_bits(input logic [7:0] pat, input logic [1:0] b);
    logic [2:0] i;
    i = 3'h7 - {b, 1'b0};
    beat_bits = {{16{pat[i - 3'h1]}}, {16{pat[i]}}};
  endfunction

  assign mr = ddr_pkg::ddr_mr_index(link.bg, link.ba);
  assign byte_sel = mpr_data_reg[sel_reg];

  // ----------------------------------------
  // Mode registers
  // ----------------------------------------
  always_comb begin
    mpr_next = mpr_reg;
    page_next = page_reg;
    train_next = train_reg;
    rpre2_next = rpre2_reg;
    wpre2_next = wpre2_reg;
    cerr_next = 1'b0;
    grp_next = grp_reg;
    if (link.cmd == ddr_pkg::CMD_MRS && mr == 3'(`DDR_MR_MPR)) begin
      mpr_next = link.addr[`DDR_MPR_EN_BIT];
      page_next = link.addr[1:0];
    end
    if (link.cmd == ddr_pkg::CMD_MRS && mr == 3'(`DDR_MR_PRE)) begin
      rpre2_next = link.addr[`DDR_RPRE_BIT];
      wpre2_next = link.addr[`DDR_WPRE_BIT];
      if (link.addr[`DDR_TRAIN_BIT] && !mpr_reg) begin
        // Enable outside MPR mode is ignored, not obeyed
        cerr_next = 1'b1;
      end else begin
        train_next = link.addr[`DDR_TRAIN_BIT];
      end
    end
    if (link.cmd == ddr_pkg::CMD_ACT || link.cmd == ddr_pkg::CMD_RD ||
        link.cmd == ddr_pkg::CMD_WR) begin
      grp_next = ddr_pkg::ddr_group(link.bg);
    end
  end

  // ----------------------------------------
  // Read and training sequencer
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    cnt_next = (cnt_reg == 5'h0) ? 5'h0 : cnt_reg - 5'h1;
    sel_next = sel_reg;
    beat_next = beat_reg;
    sready_next = sready_reg;
    case (st_reg)
      ddr_pkg::ST_IDLE: begin
        if (train_next && !train_reg) begin
          st_next = ddr_pkg::ST_SETTLE;
          cnt_next = 5'(`DDR_TSDO_CYC - 1);
        end
      end
      ddr_pkg::ST_SETTLE: begin
        if (cnt_reg == 5'h0) begin
          st_next = ddr_pkg::ST_TRAIN;
          sready_next = 1'b1;
        end
      end
      ddr_pkg::ST_TRAIN: begin
        // Static until a page-0 MPR read arrives
        if (link.cmd == ddr_pkg::CMD_RD && page_reg == 2'h0) begin
          st_next = ddr_pkg::ST_WAIT;
          sel_next = link.addr[1:0];
          cnt_next = 5'(`DDR_CL - 2);
        end
      end
      ddr_pkg::ST_WAIT: begin
        if (cnt_reg == 5'h0) begin
          st_next = ddr_pkg::ST_BURST;
          beat_next = 2'h0;
        end
      end
      ddr_pkg::ST_BURST: begin
        beat_next = beat_reg + 2'h1;
        if (beat_reg == 2'(`DDR_BURST_BEATS - 1)) begin
          st_next = ddr_pkg::ST_POST;
        end
      end
      ddr_pkg::ST_POST: begin
        st_next = train_reg ? ddr_pkg::ST_TRAIN : ddr_pkg::ST_IDLE;
      end
      default: begin
        st_next = ddr_pkg::ST_IDLE;
      end
    endcase
    if (st_reg == ddr_pkg::ST_IDLE && mpr_reg && !train_next &&
        link.cmd == ddr_pkg::CMD_RD && page_reg == 2'h0) begin
      st_next = ddr_pkg::ST_WAIT;
      sel_next = link.addr[1:0];
      cnt_next = 5'(`DDR_CL - 2);
    end
    // Exit from training drops back to idle between bursts
    if (!train_next && (st_reg == ddr_pkg::ST_TRAIN || st_reg == ddr_pkg::ST_SETTLE)) begin
      st_next = ddr_pkg::ST_IDLE;
      sready_next = 1'b0;
    end
  end

  // ----------------------------------------
  // Pin drive, registered one cycle ahead
  // ----------------------------------------
  always_comb begin
    dq_next = 32'hffffffff;
    dqoe_next = 1'b0;
    st_t_next = 2'b00;
    st_c_next = 2'b11;
    soe_next = 2'b00;
    if (train_next) begin
      dqoe_next = 1'b1;
    end
    if (st_next == ddr_pkg::ST_TRAIN || (st_next == ddr_pkg::ST_POST && train_next) ||
        (st_next == ddr_pkg::ST_WAIT && train_reg)) begin
      soe_next = 2'b11;
    end
    if (st_next == ddr_pkg::ST_WAIT &&
        (cnt_next == 5'h0 || (cnt_next == 5'h1 && rpre2_reg))) begin
      soe_next = 2'b11;
    end
    if (st_next == ddr_pkg::ST_BURST) begin
      dq_next = beat_bits(byte_sel, beat_next);
      dqoe_next = 1'b1;
      st_t_next = 2'b01;
      st_c_next = 2'b10;
      soe_next = 2'b11;
    end
    if (st_next == ddr_pkg::ST_POST && !train_next) begin
      soe_next = 2'b01;
    end
  end

  // ----------------------------------------
  // Write postamble watch
  // ----------------------------------------
  always_comb begin
    wc_next = (wc_reg == 5'h0) ? 5'h0 : wc_reg - 5'h1;
    werr_next = 1'b0;
    if (link.cmd == ddr_pkg::CMD_WR) begin
      wc_next = 5'(`DDR_CWL + `DDR_BURST_BEATS);
    end
    if (wc_reg == 5'h1 && link.dqs_oe_h != 2'b01) begin
      werr_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= ddr_pkg::ST_IDLE;
      mpr_reg <= 1'b0;
      page_reg <= 2'h0;
      train_reg <= 1'b0;
      rpre2_reg <= 1'b0;
      wpre2_reg <= 1'b0;
      mpr_data_reg[0] <= `DDR_MPR0_RST;
      mpr_data_reg[1] <= `DDR_MPR1_RST;
      mpr_data_reg[2] <= `DDR_MPR2_RST;
      mpr_data_reg[3] <= `DDR_MPR3_RST;
      sel_reg <= 2'h0;
      cnt_reg <= 5'h0;
      beat_reg <= 2'h0;
      dq_reg <= 32'hffffffff;
      dqoe_reg <= 1'b0;
      st_t_reg <= 2'b00;
      st_c_reg <= 2'b11;
      soe_reg <= 2'b00;
      sready_reg <= 1'b0;
      cerr_reg <= 1'b0;
      werr_reg <= 1'b0;
      wc_reg <= 5'h0;
      grp_reg <= 2'h0;
    end else begin
      st_reg <= st_next;
      mpr_reg <= mpr_next;
      page_reg <= page_next;
      train_reg <= train_next;
      rpre2_reg <= rpre2_next;
      wpre2_reg <= wpre2_next;
      sel_reg <= sel_next;
      cnt_reg <= cnt_next;
      beat_reg <= beat_next;
      dq_reg <= dq_next;
      dqoe_reg <= dqoe_next;
      st_t_reg <= st_t_next;
      st_c_reg <= st_c_next;
      soe_reg <= soe_next;
      sready_reg <= sready_next;
      cerr_reg <= cerr_next;
      werr_reg <= werr_next;
      wc_reg <= wc_next;
      grp_reg <= grp_next;
    end
  end

  assign link.dq_d = dq_reg;
  assign link.dq_d_oe = dqoe_reg;
  assign link.dqs_t_d = st_t_reg;
  assign link.dqs_c_d = st_c_reg;
  assign link.dqs_oe_d = soe_reg;
  assign mpr_on = mpr_reg;
  assign train_on = train_reg;
  assign strobe_ready = sready_reg;
  assign rd_pre2 = rpre2_reg;
  assign wr_pre2 = wpre2_reg;
  assign cmd_err = cerr_reg;
  assign wpost_err = werr_reg;
  assign last_group = grp_reg;
endmodule
`default_nettype wire

// >>> design/ddr_params.svh
// Timing constants and register field positions for the training link
//
// Overview of operation
// - Preamble training only allowed in MPR mode
// - MR4 bit 10 set enables, clear disables
// - Strobes valid by tSDO after enable
// - Idle training holds all DQ lines HIGH
// - Training holds true strobe LOW, complement HIGH
// - Page-0 MPR read bursts after CL
// - Controller exits training by clearing MR4 bit10
// - Write postamble is half a clock
// - Read postamble is half a clock outside training
// - x16 has two groups of four banks
// - Column spacing short across, long within group
// - Spacing honours larger of clocks and nanoseconds
// - Activate spacing short across, long within group
// - tWTR_S before read to other group
// - tWTR_L before read to same group
`ifndef DDR_PARAMS_SVH
`define DDR_PARAMS_SVH

// ----------------------------------------
// Clock and latencies
// ----------------------------------------
`define DDR_TCK_PS 8000
`define DDR_CL 11
`define DDR_CWL 9
`define DDR_BURST_BEATS 4

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define DDR_MR_MPR 3
`define DDR_MR_PRE 4
`define DDR_MPR_EN_BIT 2
`define DDR_TRAIN_BIT 10
`define DDR_RPRE_BIT 11
`define DDR_WPRE_BIT 12
`define DDR_MPR0_RST 8'h55
`define DDR_MPR1_RST 8'h33
`define DDR_MPR2_RST 8'h0f
`define DDR_MPR3_RST 8'h00

// ----------------------------------------
// Spacing figures, clocks and picoseconds
// ----------------------------------------
`define DDR_CYC(nck, ps) (((nck) > (((ps) + `DDR_TCK_PS - 1) / `DDR_TCK_PS)) ? \
  (nck) : (((ps) + `DDR_TCK_PS - 1) / `DDR_TCK_PS))
`define DDR_TCCD_S_NCK 4
`define DDR_TCCD_L_NCK 4
`define DDR_TCCD_L_PS 6250
`define DDR_TRRD_S_NCK 4
`define DDR_TRRD_S_PS 5000
`define DDR_TRRD_L_NCK 4
`define DDR_TRRD_L_PS 6000
`define DDR_TWTR_S_NCK 2
`define DDR_TWTR_S_PS 2500
`define DDR_TWTR_L_NCK 4
`define DDR_TWTR_L_PS 7500
`define DDR_TCCD_S_CYC `DDR_TCCD_S_NCK
`define DDR_TCCD_L_CYC `DDR_CYC(`DDR_TCCD_L_NCK, `DDR_TCCD_L_PS)
`define DDR_TRRD_S_CYC `DDR_CYC(`DDR_TRRD_S_NCK, `DDR_TRRD_S_PS)
`define DDR_TRRD_L_CYC `DDR_CYC(`DDR_TRRD_L_NCK, `DDR_TRRD_L_PS)
`define DDR_TWTR_S_CYC `DDR_CYC(`DDR_TWTR_S_NCK, `DDR_TWTR_S_PS)
`define DDR_TWTR_L_CYC `DDR_CYC(`DDR_TWTR_L_NCK, `DDR_TWTR_L_PS)
// Plain default; longest time, rounded down
`define DDR_TSDO_PS 20000
`define DDR_TSDO_CYC (((`DDR_TSDO_PS / `DDR_TCK_PS) < 1) ? 1 : (`DDR_TSDO_PS / `DDR_TCK_PS))

`endif

// >>> design/ddr_pkg.sv
// Types shared by both ends of the link
package ddr_pkg;

  typedef enum logic [2:0] {
    CMD_DES = 3'h0,
    CMD_MRS = 3'h1,
    CMD_ACT = 3'h2,
    CMD_RD = 3'h3,
    CMD_WR = 3'h4
  } ddr_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETTLE = 3'h1,
    ST_TRAIN = 3'h2,
    ST_WAIT = 3'h3,
    ST_BURST = 3'h4,
    ST_POST = 3'h5
  } ddr_dev_st_t;

  // x16: only BG[0] selects a group
  function automatic logic [1:0] ddr_group(input logic [1:0] bg);
    ddr_group = {1'b0, bg[0]};
  endfunction

  // Mode register index from BG[0] and BA
  function automatic logic [2:0] ddr_mr_index(input logic [1:0] bg, input logic [1:0] ba);
    ddr_mr_index = {bg[0], ba};
  endfunction

endpackage

// >>> design/ddr_link_if.sv
// Command and data link between controller and memory device
`timescale 1ns/1ps
`default_nettype none
interface ddr_link_if;
  ddr_pkg::ddr_cmd_t cmd;
  logic [1:0] bg;
  logic [1:0] ba;
  logic [13:0] addr;
  // Two halves per clock: [15:0] first, [31:16] second
  logic [31:0] dq_d;
  logic dq_d_oe;
  logic [31:0] dq_h;
  logic dq_h_oe;
  logic [1:0] dqs_t_d;
  logic [1:0] dqs_c_d;
  logic [1:0] dqs_oe_d;
  logic [1:0] dqs_t_h;
  logic [1:0] dqs_c_h;
  logic [1:0] dqs_oe_h;
  logic [31:0] dq;
  logic [1:0] dqs_t;
  logic [1:0] dqs_c;

  // Pseudo open drain: undriven lines float HIGH
  assign dq = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : 32'hffffffff);
  assign dqs_t = (dqs_oe_d & dqs_t_d) | (dqs_oe_h & dqs_t_h) | ~(dqs_oe_d | dqs_oe_h);
  assign dqs_c = (dqs_oe_d & dqs_c_d) | (dqs_oe_h & dqs_c_h) | ~(dqs_oe_d | dqs_oe_h);

  modport dev (
    input cmd, bg, ba, addr, dq, dqs_oe_h,
    output dq_d, dq_d_oe, dqs_t_d, dqs_c_d, dqs_oe_d
  );
  modport host (
    input dq, dqs_t, dqs_c,
    output cmd, bg, ba, addr, dq_h, dq_h_oe, dqs_t_h, dqs_c_h, dqs_oe_h
  );
endinterface
`default_nettype wire

// >>> design/ddr_gap.sv
// Per-bank-group spacing tracker for the controller
`include "ddr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ddr_gap (
  // System
  input wire logic clock,
  input wire logic rst,
  // Candidate and issue
  input wire ddr_pkg::ddr_cmd_t cmd,
  input wire logic [1:0] bg,
  input wire logic issue,
  // Verdict
  output logic ok
);
  logic [4:0] col_reg [4];
  logic [4:0] act_reg [4];
  logic [4:0] wtr_reg [4];
  logic [4:0] col_next [4];
  logic [4:0] act_next [4];
  logic [4:0] wtr_next [4];
  logic [1:0] g;

  function automatic logic [4:0] dec_max(input logic [4:0] cur, input logic [4:0] load);
    logic [4:0] d;
    d = (cur == 5'h0) ? 5'h0 : cur - 5'h1;
    dec_max = (load > d) ? load : d;
  endfunction

  assign g = ddr_pkg::ddr_group(bg);

  always_comb begin
    case (cmd)
      ddr_pkg::CMD_RD: ok = (col_reg[g] == 5'h0) && (wtr_reg[g] == 5'h0);
      ddr_pkg::CMD_WR: ok = (col_reg[g] == 5'h0);
      ddr_pkg::CMD_ACT: ok = (act_reg[g] == 5'h0);
      default: ok = 1'b1;
    endcase
  end

  always_comb begin
    for (int h = 0; h < 4; h++) begin
      col_next[h] = dec_max(col_reg[h], 5'h0);
      act_next[h] = dec_max(act_reg[h], 5'h0);
      wtr_next[h] = dec_max(wtr_reg[h], 5'h0);
      if (issue) begin
        if (cmd == ddr_pkg::CMD_RD || cmd == ddr_pkg::CMD_WR) begin
          col_next[h] = dec_max(col_reg[h], (h[1:0] == g) ?
            5'(`DDR_TCCD_L_CYC - 1) : 5'(`DDR_TCCD_S_CYC - 1));
        end
        if (cmd == ddr_pkg::CMD_ACT) begin
          act_next[h] = dec_max(act_reg[h], (h[1:0] == g) ?
            5'(`DDR_TRRD_L_CYC - 1) : 5'(`DDR_TRRD_S_CYC - 1));
        end
        // Internal write starts after the burst lands
        if (cmd == ddr_pkg::CMD_WR) begin
          wtr_next[h] = dec_max(wtr_reg[h], (h[1:0] == g) ?
            5'(`DDR_CWL + `DDR_BURST_BEATS + `DDR_TWTR_L_CYC - 1) :
            5'(`DDR_CWL + `DDR_BURST_BEATS + `DDR_TWTR_S_CYC - 1));
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    for (int h = 0; h < 4; h++) begin
      if (rst) begin
        col_reg[h] <= 5'h0;
        act_reg[h] <= 5'h0;
        wtr_reg[h] <= 5'h0;
      end else begin
        col_reg[h] <= col_next[h];
        act_reg[h] <= act_next[h];
        wtr_reg[h] <= wtr_next[h];
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/ddr_host.sv
// Controller end: issues commands with bank-group spacing, drives write strobes
`include "ddr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ddr_host (
  // System
  input wire logic clock,
  input wire logic rst,
  // Link
  ddr_link_if.host link,
  // Request
  input wire logic req_valid,
  input wire ddr_pkg::ddr_cmd_t req_cmd,
  input wire logic [1:0] req_bg,
  input wire logic [1:0] req_ba,
  input wire logic [13:0] req_addr,
  input wire logic [127:0] req_wdata,
  output logic req_ready,
  output logic req_err,
  // Read return
  output logic rd_valid,
  output logic [127:0] rd_data
);
  logic hv_reg, hv_next;
  ddr_pkg::ddr_cmd_t hc_reg, hc_next, cmd_reg, cmd_next;
  logic [1:0] hbg_reg, hbg_next, hba_reg, hba_next, bg_reg, bg_next, ba_reg, ba_next;
  logic [13:0] ha_reg, ha_next, a_reg, a_next;
  logic [127:0] hw_reg, hw_next, wd_reg, wd_next, rdd_reg, rdd_next;
  logic mpr_reg, mpr_next, wpre2_reg, wpre2_next, err_reg, err_next, rv_reg, rv_next;
  logic [4:0] wc_reg, wc_next, rc_reg, rc_next;
  logic [31:0] dq_reg, dq_next;
  logic dqoe_reg, dqoe_next;
  logic [1:0] st_reg, st_next, soe_reg, soe_next;
  logic ok, issue, bad;

  ddr_gap u_gap (
    .clock(clock),
    .rst(rst),
    .cmd(hc_reg),
    .bg(hbg_reg),
    .issue(issue),
    .ok(ok)
  );

  assign issue = hv_reg && ok;
  // Refuse training enable outside MPR mode
  assign bad = req_valid && !hv_reg && req_cmd == ddr_pkg::CMD_MRS &&
    ddr_pkg::ddr_mr_index(req_bg, req_ba) == 3'(`DDR_MR_PRE) &&
    req_addr[`DDR_TRAIN_BIT] && !mpr_reg;

  always_comb begin
    hv_next = hv_reg && !issue;
    hc_next = hc_reg;
    hbg_next = hbg_reg;
    hba_next = hba_reg;
    ha_next = ha_reg;
    hw_next = hw_reg;
    err_next = bad;
    if (req_valid && !hv_reg && !bad) begin
      hv_next = 1'b1;
      hc_next = req_cmd;
      hbg_next = req_bg;
      hba_next = req_ba;
      ha_next = req_addr;
      hw_next = req_wdata;
    end
  end

  always_comb begin
    cmd_next = issue ? hc_reg : ddr_pkg::CMD_DES;
    bg_next = hbg_reg;
    ba_next = hba_reg;
    a_next = ha_reg;
    mpr_next = mpr_reg;
    wpre2_next = wpre2_reg;
    if (issue && hc_reg == ddr_pkg::CMD_MRS) begin
      if (ddr_pkg::ddr_mr_index(hbg_reg, hba_reg) == 3'(`DDR_MR_MPR)) begin
        mpr_next = ha_reg[`DDR_MPR_EN_BIT];
      end
      if (ddr_pkg::ddr_mr_index(hbg_reg, hba_reg) == 3'(`DDR_MR_PRE)) begin
        wpre2_next = ha_reg[`DDR_WPRE_BIT];
      end
    end
  end

  // Write strobe and data: preamble, four beats, half-clock postamble
  always_comb begin
    wc_next = (wc_reg == 5'h0) ? 5'h0 : wc_reg - 5'h1;
    wd_next = wd_reg;
    if (issue && hc_reg == ddr_pkg::CMD_WR) begin
      wc_next = 5'(`DDR_CWL + 5);
      wd_next = hw_reg;
    end
    dq_next = 32'hffffffff;
    dqoe_next = 1'b0;
    st_next = 2'b00;
    soe_next = 2'b00;
    if (wc_reg == 5'h7 || (wc_reg == 5'h8 && wpre2_reg)) begin
      soe_next = 2'b11;
    end else if (wc_reg >= 5'h3 && wc_reg <= 5'h6) begin
      st_next = 2'b01;
      soe_next = 2'b11;
      dqoe_next = 1'b1;
      dq_next = wd_reg[32 * (6 - wc_reg) +: 32];
    end else if (wc_reg == 5'h2) begin
      soe_next = 2'b01;
    end
  end

  // Read capture at CL after the command
  always_comb begin
    rc_next = (rc_reg == 5'h0) ? 5'h0 : rc_reg - 5'h1;
    rdd_next = rdd_reg;
    rv_next = 1'b0;
    if (issue && hc_reg == ddr_pkg::CMD_RD) begin
      rc_next = 5'(`DDR_CL + 4);
    end
    if (rc_reg >= 5'h1 && rc_reg <= 5'h4) begin
      rdd_next[32 * (4 - rc_reg) +: 32] = link.dq;
      rv_next = (rc_reg == 5'h1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      hv_reg <= 1'b0;
      hc_reg <= ddr_pkg::CMD_DES;
      hbg_reg <= 2'h0;
      hba_reg <= 2'h0;
      ha_reg <= 14'h0;
      hw_reg <= 128'h0;
      cmd_reg <= ddr_pkg::CMD_DES;
      bg_reg <= 2'h0;
      ba_reg <= 2'h0;
      a_reg <= 14'h0;
      mpr_reg <= 1'b0;
      wpre2_reg <= 1'b0;
      err_reg <= 1'b0;
      wc_reg <= 5'h0;
      wd_reg <= 128'h0;
      dq_reg <= 32'hffffffff;
      dqoe_reg <= 1'b0;
      st_reg <= 2'b00;
      soe_reg <= 2'b00;
      rc_reg <= 5'h0;
      rdd_reg <= 128'h0;
      rv_reg <= 1'b0;
    end else begin
      hv_reg <= hv_next;
      hc_reg <= hc_next;
      hbg_reg <= hbg_next;
      hba_reg <= hba_next;
      ha_reg <= ha_next;
      hw_reg <= hw_next;
      cmd_reg <= cmd_next;
      bg_reg <= bg_next;
      ba_reg <= ba_next;
      a_reg <= a_next;
      mpr_reg <= mpr_next;
      wpre2_reg <= wpre2_next;
      err_reg <= err_next;
      wc_reg <= wc_next;
      wd_reg <= wd_next;
      dq_reg <= dq_next;
      dqoe_reg <= dqoe_next;
      st_reg <= st_next;
      soe_reg <= soe_next;
      rc_reg <= rc_next;
      rdd_reg <= rdd_next;
      rv_reg <= rv_next;
    end
  end

  assign link.cmd = cmd_reg;
  assign link.bg = bg_reg;
  assign link.ba = ba_reg;
  assign link.addr = a_reg;
  assign link.dq_h = dq_reg;
  assign link.dq_h_oe = dqoe_reg;
  assign link.dqs_t_h = st_reg;
  assign link.dqs_c_h = ~st_reg;
  assign link.dqs_oe_h = soe_reg;
  assign req_ready = !hv_reg;
  assign req_err = err_reg;
  assign rd_valid = rv_reg;
  assign rd_data = rdd_reg;
endmodule
`default_nettype wire

// >>> test/ddr_link_sva.sv
// Link checker: command spacing, training strobes and postambles
`include "ddr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ddr_link_sva (
  // System
  input wire logic clock,
  input wire logic rst,
  // Link
  input var ddr_pkg::ddr_cmd_t cmd,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic [13:0] addr,
  input wire logic [31:0] dq,
  input wire logic dq_d_oe,
  input wire logic [1:0] dqs_t,
  input wire logic [1:0] dqs_c,
  input wire logic [1:0] dqs_oe_d,
  input wire logic [1:0] dqs_oe_h
);
  localparam int WPOST = `DDR_CWL + 4;
  localparam int RPOST = `DDR_CL + 4;
  logic mpr_reg, mpr_next, train_reg, train_next, wbg_reg, wbg_next;
  logic mr3, mr4, rd, wr, act, col;
  assign mr3 = cmd == ddr_pkg::CMD_MRS && {bg[0], ba} == 3'h3;
  assign mr4 = cmd == ddr_pkg::CMD_MRS && {bg[0], ba} == 3'h4;
  assign rd = cmd == ddr_pkg::CMD_RD;
  assign wr = cmd == ddr_pkg::CMD_WR;
  assign act = cmd == ddr_pkg::CMD_ACT;
  assign col = rd || wr;
  always_comb begin
    mpr_next = mr3 ? addr[2] : mpr_reg;
    train_next = mr4 ? addr[10] : train_reg;
    wbg_next = wr ? bg[0] : wbg_reg;
    if (rst) begin
      mpr_next = 1'b0;
      train_next = 1'b0;
      wbg_next = 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    mpr_reg <= mpr_next;
    train_reg <= train_next;
    wbg_reg <= wbg_next;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_train_en; mr4 && addr[10] && mpr_reg && !train_reg; endsequence
  sequence s_mpr_rd; rd && mpr_reg; endsequence
  a_col_spacing: assert property (col |=> !col [*3])
    else $error("column commands too close");
  a_act_spacing: assert property (act |=> !act [*3])
    else $error("activates too close");
  a_wtr_short: assert property (wr |=> !rd [*7] ##1 !rd [*7])
    else $error("read too soon after write");
  a_wtr_long: assert property (wr |=> (!(rd && bg[0] == wbg_reg)) [*8] ##1
    (!(rd && bg[0] == wbg_reg)) [*8]) else $error("same group read too soon after write");
  a_train_gate: assert property (mr4 && addr[10] |-> mpr_reg)
    else $error("training enabled outside register mode");
  a_train_quiet: assert property (s_train_en |=> dq_d_oe && dq == 32'hffffffff)
    else $error("data lines not held high");
  a_strobe_settle: assert property (s_train_en |-> ##3
    dqs_oe_d == 2'h3 && dqs_t == 2'h0 && dqs_c == 2'h3) else $error("strobe not static");
  a_burst_toggle: assert property (s_mpr_rd |-> ##11
    (dqs_t == 2'h1 && dqs_c == 2'h2) [*4]) else $error("read burst strobe wrong");
  a_read_post: assert property ((s_mpr_rd and !train_reg) |-> ##RPOST
    dqs_oe_d == 2'h1 ##1 dqs_oe_d == 2'h0) else $error("read postamble wrong");
  a_write_post: assert property (wr |-> ##(WPOST - 4) dqs_oe_h == 2'h3 [*4] ##1
    dqs_oe_h[0]) else $error("write strobe window wrong");
  a_wpost_shape: assert property ($past(dqs_oe_h) == 2'h3 && dqs_oe_h != 2'h3
    |-> dqs_oe_h == 2'h1) else $error("write postamble not half clock");
endmodule
`default_nettype wire

// >>> test/bank_group_timing_and_preamble_training_test.sv
// Bench joining controller and device end to end
`include "ddr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module bank_group_timing_and_preamble_training_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  ddr_pkg::ddr_cmd_t req_cmd = ddr_pkg::CMD_DES;
  logic [1:0] req_bg = 2'h0;
  logic [1:0] req_ba = 2'h0;
  logic [13:0] req_addr = 14'h0;
  logic [127:0] req_wdata = 128'h0;
  logic req_ready, req_err, rd_valid, mpr_on, train_on, strobe_ready, rd_pre2, wr_pre2;
  logic cmd_err, wpost_err;
  logic [1:0] last_group, r;
  logic [127:0] rd_data;
  logic [127:0] exp_q[$];
  logic err_q[$];
  ddr_pkg::ddr_cmd_t ops[3] = '{ddr_pkg::CMD_ACT, ddr_pkg::CMD_WR, ddr_pkg::CMD_RD};
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int pick = 0;
  ddr_link_if link();
  always #4 clock = ~clock;
  ddr_host i_ddr_host (.clock(clock), .rst(rst), .link(link), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_bg(req_bg), .req_ba(req_ba), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .req_err(req_err), .rd_valid(rd_valid),
    .rd_data(rd_data));
  ddr_dev i_ddr_dev (.clock(clock), .rst(rst), .link(link), .mpr_on(mpr_on),
    .train_on(train_on), .strobe_ready(strobe_ready), .rd_pre2(rd_pre2), .wr_pre2(wr_pre2),
    .cmd_err(cmd_err), .wpost_err(wpost_err), .last_group(last_group));
  ddr_link_sva i_ddr_link_sva (.clock(clock), .rst(rst), .cmd(link.cmd), .bg(link.bg),
    .ba(link.ba), .addr(link.addr), .dq(link.dq), .dq_d_oe(link.dq_d_oe),
    .dqs_t(link.dqs_t), .dqs_c(link.dqs_c), .dqs_oe_d(link.dqs_oe_d),
    .dqs_oe_h(link.dqs_oe_h));

  task automatic chk_data(input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic [3:0] got, input logic [3:0] exp);
    chk_data({124'h0, got}, {124'h0, exp});
  endtask

  task automatic tally_and_finish;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Register pattern as returned: two bits per beat, one per half clock
  function automatic logic [127:0] mpr_exp(input logic [1:0] s);
    logic [7:0] m;
    m = s == 2'h0 ? `DDR_MPR0_RST : s == 2'h1 ? `DDR_MPR1_RST :
      s == 2'h2 ? `DDR_MPR2_RST : `DDR_MPR3_RST;
    for (int k = 0; k < 4; k++) begin
      mpr_exp[32 * k +: 32] = {{16{m[6 - 2 * k]}}, {16{m[7 - 2 * k]}}};
    end
  endfunction

  task automatic req(input ddr_pkg::ddr_cmd_t c, input logic [1:0] g, input logic [1:0] b,
                     input logic [13:0] a);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bg <= g;
    req_ba <= b;
    req_addr <= a;
    req_wdata <= {$urandom, $urandom, $urandom, $urandom};
    @(posedge clock);
    while (req_ready !== 1'b1) @(posedge clock);
    req_valid <= 1'b0;
    @(posedge clock);
    while (req_ready !== 1'b1) @(posedge clock);
  endtask

  // Random group and bank; w = 0 keeps commands back to back
  task automatic op(input ddr_pkg::ddr_cmd_t c, input logic [1:0] s, input logic [127:0] e,
                    input int w);
    logic [1:0] g;
    g = 2'($urandom);
    if (c == ddr_pkg::CMD_RD) exp_q.push_back(e);
    req(c, g, 2'($urandom), {12'h0, s});
    if (w > 0) begin
      repeat (3) @(posedge clock);
      chk_flag({2'h0, last_group}, {3'h0, g[0]});
      repeat (w) @(posedge clock);
    end
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      tally_and_finish();
    end
    if (rd_valid === 1'b1) chk_data(rd_data, exp_q.size() ? exp_q.pop_front() : 'x);
    if (req_err === 1'b1) chk_flag({3'h0, req_err}, {3'h0, err_q.size() > 0});
    if (req_err === 1'b1 && err_q.size() > 0) void'(err_q.pop_front());
    if (cmd_err === 1'b1 || wpost_err === 1'b1) chk_flag({2'h0, cmd_err, wpost_err}, 4'h0);
  end

  initial begin
    void'($urandom(32'hf96b));
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    chk_flag({3'h0, req_ready}, 4'h1);
    err_q.push_back(1'b1);
    req(ddr_pkg::CMD_MRS, 2'h1, 2'h0, 14'h0400);
    repeat (4) @(posedge clock);
    chk_flag({2'h0, train_on, cmd_err}, 4'h0);
    $display("refusal test done");
    req(ddr_pkg::CMD_MRS, 2'h0, 2'h3, 14'h0004);
    for (int s = 0; s < 4; s++) op(ddr_pkg::CMD_RD, 2'(s), mpr_exp(2'(s)), 20);
    $display("register read test done");
    r = 2'($urandom);
    req(ddr_pkg::CMD_MRS, 2'h1, 2'h0, {1'b0, r, 11'h400});
    repeat (4) @(posedge clock);
    chk_flag({train_on, strobe_ready, wr_pre2, rd_pre2}, {2'h3, r});
    chk_flag({link.dqs_t, link.dqs_c}, 4'h3);
    chk_data({96'h0, link.dq}, {96'h0, 32'hffffffff});
    for (int s = 0; s < 4; s++) op(ddr_pkg::CMD_RD, 2'(s), mpr_exp(2'(s)), 20);
    chk_flag({link.dqs_t, link.dqs_c}, 4'h3);
    req(ddr_pkg::CMD_MRS, 2'h1, 2'h0, 14'h0);
    repeat (4) @(posedge clock);
    chk_flag({3'h0, train_on}, 4'h0);
    $display("training test done");
    req(ddr_pkg::CMD_MRS, 2'h0, 2'h3, 14'h0);
    // Undriven data floats high, so ordinary reads return all ones
    for (int i = 0; i < 40; i++) begin
      // Column bursts must not overlap; the tracker still sets read-after-write spacing
      pick = $urandom_range(2);
      op(ops[pick], 2'h0, '1, (pick == 0) ? 0 : 9);
    end
    repeat (40) @(posedge clock);
    chk_flag(4'(exp_q.size() + err_q.size()), 4'h0);
    $display("spacing test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
